/* File: src/csda_pkg.sv */
// Shared constants for the compare, skip and decimal adjust unit.
package csda_pkg;

  // Register byte addresses on the control bus.
  localparam logic [7:0] ADDR_WORKING_REGISTER_ALIAS  = 8'h00;  // Working register.
  localparam logic [7:0] ADDR_FLAGS = 8'h04;  // Carry and digit carry.
  localparam logic [7:0] ADDR_BANK  = 8'h08;  // Bank select.
  localparam logic [7:0] ADDR_IDX   = 8'h0c;  // Index base for literal offset.
  localparam logic [7:0] ADDR_CTRL  = 8'h10;  // Extended set enable.
  localparam logic [7:0] ADDR_STAT  = 8'h14;  // Execution state, read only.

  // Field positions.
  localparam int FLAG_C_BIT   = 0;  // Carry.
  localparam int FLAG_DC_BIT  = 1;  // Digit carry.
  localparam int CTRL_EXT_BIT = 0;  // Extended instruction set.

  // Reset values.
  localparam logic [7:0]  WORKING_REGISTER_ALIAS_RST = 8'h00;
  localparam logic [3:0]  BANK_RST = 4'h0;
  localparam logic [11:0] IDX_RST  = 12'h000;

  // Opcode patterns.
  localparam logic [6:0]  OP_GT_TOP  = 7'h32;    // 0110 010a.
  localparam logic [6:0]  OP_LT_TOP  = 7'h30;    // 0110 000a.
  localparam logic [15:0] OP_DAW     = 16'h0007;
  localparam logic [3:0]  OP_2W_FF   = 4'hc;     // Two-word register move.
  localparam logic [5:0]  OP_2W_JMP  = 6'h3b;    // Two-word call, goto, load.

  // Addressing and decimal adjust constants.
  localparam logic [7:0] ILO_MAX   = 8'h5f;  // Highest literal offset, 95.
  localparam logic [7:0] ACC_SPLIT = 8'h60;  // Access bank split point.
  localparam logic [3:0] ACC_HIGH  = 4'hf;   // Upper access bank page.
  localparam logic [3:0] BCD_MAX   = 4'h9;   // Largest decimal digit.
  localparam logic [3:0] BCD_FIX   = 4'h6;   // Decimal correction.

  // Timing counts.
  localparam logic [1:0] PHASE_LAST = 2'h3;  // Four phases per cycle.

  // Decoded instruction kinds.
  typedef enum logic [1:0] {K_NONE, K_GT, K_LT, K_DAW} csda_kind_t;

  // True when a word opens a two-word instruction.
  function automatic logic csda_two_word(input logic [15:0] op);
    return (op[15:12] == OP_2W_FF) || (op[15:10] == OP_2W_JMP);
  endfunction : csda_two_word

endpackage : csda_pkg

/* File: src/csda_alu_if.sv */
`timescale 1ns/1ps
`default_nettype none
// Carries operands to the decode and arithmetic unit and results back.
interface csda_alu_if;
  import csda_pkg::*;
  logic [15:0] opcode;   // Instruction word under decode.
  logic [7:0]  w;        // Working register value.
  logic [7:0]  fdata;    // Addressed data memory byte.
  logic        c;        // Carry in.
  logic        dc;       // Digit carry in.
  csda_kind_t  kind;     // Decoded kind.
  logic        skip;     // Compare condition holds.
  logic [7:0]  daw_w;    // Adjusted working register.
  logic        daw_c;    // Carry after adjust.
  modport exec (output opcode, w, fdata, c, dc, input kind, skip, daw_w, daw_c);
  modport alu  (input opcode, w, fdata, c, dc, output kind, skip, daw_w, daw_c);
endinterface : csda_alu_if
`default_nettype wire

/* File: src/csda_alu.sv */
`timescale 1ns/1ps
`default_nettype none
// Decodes the instruction word and evaluates compares and decimal adjust.
module csda_alu
  import csda_pkg::*;
(
  // Operand and result carrier.
  csda_alu_if.alu bus
);

  logic [8:0] diff;     // Unsigned f minus w with borrow.
  logic [4:0] lo_sum;   // Low nibble after correction.
  logic [4:0] hi_sum;   // High nibble after low carry and correction.
  logic       hi_fix;   // High nibble needs correction.

  // Decode the opcode into a kind.
  always_comb begin
    if (bus.opcode[15:9] == OP_GT_TOP) begin  // RULE1
      bus.kind = K_GT;
    end else if (bus.opcode[15:9] == OP_LT_TOP) begin  // RULE2
      bus.kind = K_LT;
    end else if (bus.opcode == OP_DAW) begin  // RULE8
      bus.kind = K_DAW;
    end else begin
      bus.kind = K_NONE;
    end
  end

  // Both compares come from one unsigned subtraction, no flag is touched.
  always_comb begin
    diff = {1'b0, bus.fdata} - {1'b0, bus.w};  // RULE3
    if (bus.kind == K_GT) begin
      bus.skip = !diff[8] && (diff[7:0] != 8'h00);  // RULE1
    end else if (bus.kind == K_LT) begin
      bus.skip = diff[8];  // RULE2
    end else begin
      bus.skip = 1'b0;
    end
  end

  // Decimal adjust, low nibble first, then high nibble with its carry.
  always_comb begin
    if ((bus.w[3:0] > BCD_MAX) || bus.dc) begin
      lo_sum = {1'b0, bus.w[3:0]} + {1'b0, BCD_FIX};  // RULE9
    end else begin
      lo_sum = {1'b0, bus.w[3:0]};
    end
    hi_sum = {1'b0, bus.w[7:4]} + {4'h0, lo_sum[4]};
    hi_fix = (hi_sum > {1'b0, BCD_MAX}) || bus.c;  // RULE11
    if (hi_fix) begin
      hi_sum = hi_sum + {1'b0, BCD_FIX};
    end
    bus.daw_w = {hi_sum[3:0], lo_sum[3:0]};  // RULE10
    bus.daw_c = hi_fix ? 1'b1 : bus.c;  // RULE11
  end

endmodule : csda_alu
`default_nettype wire

/* File: src/csda_exec_unit.sv */
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// RULE1: Greater pattern skips when byte above W.
// RULE2: Less pattern skips when byte below W.
// RULE3: Compare by unsigned subtract, nothing changed.
// RULE4: True compare replaces next word by no-op.
// RULE5: Skipped two-word instruction costs three cycles total.
// RULE6: Bit clear uses access bank, set uses bank.
// RULE7: Greater compare uses literal offset when extended.
// RULE8: Decimal adjust decoded, one cycle long.
// RULE9: Low nibble above nine or DC adds six.
// RULE10: Adjust yields packed BCD, only carry changes.
// RULE11: High nibble above nine or carry adds six.
// RULE12: Decode, read, process, then write W for adjust.
module csda_exec_unit
  import csda_pkg::*;
(
  // Clock and reset.
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // Control bus write address, data and response.
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // Control bus read.
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Instruction fetch.
  input  wire logic [15:0] fetch_insn,
  input  wire logic [15:0] fetch_next,
  input  wire logic        fetch_valid,
  output logic             fetch_ready,
  // Data memory.
  output logic [11:0]      dmem_addr,
  output logic             dmem_rd,
  input  wire logic [7:0]  dmem_rdata,
  // Core state.
  output logic [7:0]       working_register_alias,
  output logic [1:0]       phase,
  output logic             no_operation
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations.

  typedef enum logic [1:0] {S_IDLE, S_EXEC, S_SKIP2, S_SKIP1} csda_state_t;

  csda_state_t state_q, state_d;  // Sequencer state.
  logic [1:0]  phase_q, phase_d;  // Phase within the cycle.
  logic [15:0] insn_q;            // Executing instruction.
  logic [15:0] next_q;            // Already fetched next word.
  csda_kind_t  kind_q;            // Kind decoded in the first phase.
  logic        skip_q;            // Skip condition from the third phase.
  logic        ready_q;           // Fetch ready.
  logic        nop_q;             // Discarding a word.
  logic [11:0] addr_q, addr_d;    // Operand address.
  logic        rd_q;              // Operand read strobe.
  logic [7:0]  w_q;               // Working register.
  logic        c_q, dc_q;         // Status flags.
  logic [3:0]  bsr_q;             // Bank select register.
  logic [11:0] idx_q;             // Literal offset base.
  logic        ext_q;             // Extended set enabled.
  logic        take;              // Instruction accepted.
  logic        q4_daw;            // Last phase of an adjust.
  // Bus slave state.
  logic        awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
  logic [7:0]  awaddr_q;
  logic [31:0] wdata_q, rdata_q;
  logic [3:0]  wstrb_q;
  logic        have_aw_q, have_w_q;
  logic [1:0]  bresp_q, rresp_q;
  logic        wr_fire;          // Register write this cycle.
  logic [31:0] rd_mux;           // Read data selected by address.
  logic        rd_hit;           // Read address mapped.

  csda_alu_if alu_bus ();

  ////////////////////////////////////////////////////////////////////////////
  // Arithmetic unit.

  assign alu_bus.opcode = insn_q;
  assign alu_bus.w      = w_q;
  assign alu_bus.fdata  = dmem_rdata;
  assign alu_bus.c      = c_q;
  assign alu_bus.dc     = dc_q;

  csda_alu u_alu (
    .bus (alu_bus.alu)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer.

  assign take   = fetch_valid && ready_q;
  assign q4_daw = (state_q == S_EXEC) && (phase_q == PHASE_LAST) && (kind_q == K_DAW);

  // Next state: four phases per cycle, skip cycles follow a true compare.
  always_comb begin
    state_d = state_q;
    phase_d = phase_q + 2'h1;
    case (state_q)
      S_IDLE: begin
        phase_d = 2'h0;
        if (take) begin
          state_d = S_EXEC;
        end
      end
      S_EXEC: begin
        if (phase_q == PHASE_LAST) begin
          if (!skip_q) begin
            state_d = S_IDLE;
          end else if (csda_two_word(next_q)) begin
            state_d = S_SKIP2;  // RULE5
          end else begin
            state_d = S_SKIP1;  // RULE4
          end
        end
      end
      S_SKIP2: begin
        if (phase_q == PHASE_LAST) begin
          state_d = S_SKIP1;  // RULE5
        end
      end
      S_SKIP1: begin
        if (phase_q == PHASE_LAST) begin
          state_d = S_IDLE;
        end
      end
      default: begin
        state_d = S_IDLE;
      end
    endcase
  end

  // State, phase and port flags follow the next state.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= S_IDLE;
      phase_q <= 2'h0;
      ready_q <= 1'b0;
      nop_q   <= 1'b0;
    end else begin
      state_q <= state_d;
      phase_q <= phase_d;
      ready_q <= (state_d == S_IDLE);
      nop_q   <= (state_d == S_SKIP1) || (state_d == S_SKIP2);  // RULE4
    end
  end

  // Latch the instruction and the fetched next word when taken.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      insn_q <= 16'h0000;
      next_q <= 16'h0000;
    end else if (take) begin
      insn_q <= fetch_insn;
      next_q <= fetch_next;
    end
  end

  // Operand address: literal offset, access bank or selected bank.
  always_comb begin
    if ((alu_bus.kind == K_GT) && ext_q && !insn_q[8] && (insn_q[7:0] <= ILO_MAX)) begin
      addr_d = idx_q + {4'h0, insn_q[7:0]};  // RULE7
    end else if (!insn_q[8]) begin
      addr_d = (insn_q[7:0] < ACC_SPLIT) ? {4'h0, insn_q[7:0]}
                                         : {ACC_HIGH, insn_q[7:0]};  // RULE6
    end else begin
      addr_d = {bsr_q, insn_q[7:0]};  // RULE6
    end
  end

  // First phase decodes and sets up the read, held during the second.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      kind_q <= K_NONE;
      addr_q <= 12'h000;
      rd_q   <= 1'b0;
    end else begin
      rd_q <= 1'b0;
      if ((state_q == S_EXEC) && (phase_q == 2'h0)) begin
        kind_q <= alu_bus.kind;  // RULE12
        addr_q <= addr_d;
        rd_q   <= (alu_bus.kind == K_GT) || (alu_bus.kind == K_LT);  // RULE12
      end
    end
  end

  // Third phase records the compare outcome.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      skip_q <= 1'b0;
    end else if ((state_q == S_EXEC) && (phase_q == 2'h2)) begin
      skip_q <= alu_bus.skip;  // RULE3
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Core registers; the adjust write in the fourth phase beats software.

  assign wr_fire = have_aw_q && have_w_q && !bvalid_q;

  // Working register.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_q <= WORKING_REGISTER_ALIAS_RST;
    end else if (q4_daw) begin
      w_q <= alu_bus.daw_w;  // RULE12
    end else if (wr_fire && (awaddr_q == ADDR_WORKING_REGISTER_ALIAS) && wstrb_q[0]) begin
      w_q <= wdata_q[7:0];
    end
  end

  // Status flags; adjust touches carry only.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      c_q  <= 1'b0;
      dc_q <= 1'b0;
    end else if (q4_daw) begin
      c_q <= alu_bus.daw_c;  // RULE10
    end else if (wr_fire && (awaddr_q == ADDR_FLAGS) && wstrb_q[0]) begin
      c_q  <= wdata_q[FLAG_C_BIT];
      dc_q <= wdata_q[FLAG_DC_BIT];
    end
  end

  // Bank, index and control registers, software only.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bsr_q <= BANK_RST;
      idx_q <= IDX_RST;
      ext_q <= 1'b0;
    end else if (wr_fire) begin
      if ((awaddr_q == ADDR_BANK) && wstrb_q[0]) begin
        bsr_q <= wdata_q[3:0];
      end
      if (awaddr_q == ADDR_IDX) begin
        if (wstrb_q[0]) begin
          idx_q[7:0] <= wdata_q[7:0];
        end
        if (wstrb_q[1]) begin
          idx_q[11:8] <= wdata_q[11:8];
        end
      end
      if ((awaddr_q == ADDR_CTRL) && wstrb_q[0]) begin
        ext_q <= wdata_q[CTRL_EXT_BIT];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus slave: address and data taken in either order, one write at a time.

  // Write channels.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_q <= 1'b0;
      wready_q  <= 1'b0;
      have_aw_q <= 1'b0;
      have_w_q  <= 1'b0;
      awaddr_q  <= 8'h00;
      wdata_q   <= 32'h0000_0000;
      wstrb_q   <= 4'h0;
      bvalid_q  <= 1'b0;
      bresp_q   <= 2'h0;
    end else begin
      awready_q <= !have_aw_q && !(s_axi_awvalid && awready_q) && !bvalid_q;
      wready_q  <= !have_w_q && !(s_axi_wvalid && wready_q) && !bvalid_q;
      if (s_axi_awvalid && awready_q) begin
        have_aw_q <= 1'b1;
        awaddr_q  <= {s_axi_awaddr[7:2], 2'b00};
      end
      if (s_axi_wvalid && wready_q) begin
        have_w_q <= 1'b1;
        wdata_q  <= s_axi_wdata;
        wstrb_q  <= s_axi_wstrb;
      end
      if (wr_fire) begin
        have_aw_q <= 1'b0;
        have_w_q  <= 1'b0;
        bvalid_q  <= 1'b1;
        bresp_q   <= (awaddr_q <= ADDR_CTRL) ? 2'h0 : 2'h3;
      end else if (bvalid_q && s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // Read data by address; unmapped reads answer with a decode error.
  always_comb begin
    rd_hit = 1'b1;
    case ({s_axi_araddr[7:2], 2'b00})
      ADDR_WORKING_REGISTER_ALIAS:  rd_mux = {24'h0, w_q};
      ADDR_FLAGS: rd_mux = {30'h0, dc_q, c_q};
      ADDR_BANK:  rd_mux = {28'h0, bsr_q};
      ADDR_IDX:   rd_mux = {20'h0, idx_q};
      ADDR_CTRL:  rd_mux = {31'h0, ext_q};
      ADDR_STAT:  rd_mux = {25'h0, nop_q, skip_q, kind_q, 1'b0, state_q};
      default: begin
        rd_mux = 32'h0000_0000;
        rd_hit = 1'b0;
      end
    endcase
  end

  // Read channels.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b0;
      rdata_q   <= 32'h0000_0000;
      rresp_q   <= 2'h0;
    end else begin
      arready_q <= !rvalid_q && !(s_axi_arvalid && arready_q);
      if (s_axi_arvalid && arready_q) begin
        rvalid_q <= 1'b1;
        rdata_q  <= rd_mux;
        rresp_q  <= rd_hit ? 2'h0 : 2'h3;
      end else if (rvalid_q && s_axi_rready) begin
        rvalid_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs.

  assign s_axi_awready          = awready_q;
  assign s_axi_wready           = wready_q;
  assign s_axi_bvalid           = bvalid_q;
  assign s_axi_bresp            = bresp_q;
  assign s_axi_arready          = arready_q;
  assign s_axi_rvalid           = rvalid_q;
  assign s_axi_rdata            = rdata_q;
  assign s_axi_rresp            = rresp_q;
  assign fetch_ready            = ready_q;
  assign dmem_addr              = addr_q;
  assign dmem_rd                = rd_q;
  assign working_register_alias = w_q;
  assign phase                  = phase_q;
  assign no_operation           = nop_q;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions.

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  logic q3_cmp;  // Third phase of a compare.
  logic q4_end;  // Last phase of an executing cycle.
  assign q3_cmp = (state_q == S_EXEC) && (phase_q == 2'h2) &&
                  ((kind_q == K_GT) || (kind_q == K_LT));
  assign q4_end = (state_q == S_EXEC) && (phase_q == PHASE_LAST);

  sequence seq_nop_cycle;
    nop_q [*4];
  endsequence
  sequence seq_back_idle;
    !nop_q && ready_q;
  endsequence

  chk_gt_skip: assert property (q3_cmp && (kind_q == K_GT) && (dmem_rdata > w_q) |=> skip_q) // RULE1
    else $error("greater compare did not skip");
  chk_lt_skip: assert property (q3_cmp && (kind_q == K_LT) |=> skip_q == ($past(dmem_rdata) < $past(w_q))) // RULE2
    else $error("less compare result wrong");
  chk_cmp_keep: assert property (q4_end && (kind_q != K_DAW) && !wr_fire |=> $stable(w_q) && $stable(c_q) && $stable(dc_q)) // RULE3
    else $error("compare changed state");
  chk_one_skip: assert property (q4_end && skip_q && !csda_two_word(next_q) |=> seq_nop_cycle ##1 seq_back_idle) // RULE4
    else $error("single skip timing wrong");
  chk_two_skip: assert property (q4_end && skip_q && csda_two_word(next_q) |=> seq_nop_cycle ##1 seq_nop_cycle ##1 seq_back_idle) // RULE5
    else $error("double skip timing wrong");
  chk_bank_addr: assert property (rd_q && insn_q[8] |-> dmem_addr == {$past(bsr_q), insn_q[7:0]}) // RULE6
    else $error("bank address wrong");
  chk_ilo_addr: assert property (rd_q && (kind_q == K_GT) && $past(ext_q) && !insn_q[8] && (insn_q[7:0] <= ILO_MAX) |-> dmem_addr == $past(idx_q) + {4'h0, insn_q[7:0]}) // RULE7
    else $error("literal offset address wrong");
  chk_daw_cycle: assert property (take && (fetch_insn == OP_DAW) |=> (state_q == S_EXEC) [*4] ##1 ready_q) // RULE8
    else $error("adjust not one cycle");
  chk_daw_low: assert property (q4_daw && ((w_q[3:0] > BCD_MAX) || dc_q) |=> w_q[3:0] == $past(w_q[3:0]) + BCD_FIX) // RULE9
    else $error("low nibble not corrected");
  chk_daw_dc: assert property (q4_daw && !wr_fire |=> $stable(dc_q)) // RULE10
    else $error("adjust changed digit carry");
  chk_daw_carry: assert property (q4_daw && c_q |=> c_q && (w_q[7:4] == $past(w_q[7:4]) + {3'h0, $past(w_q[3:0]) > BCD_MAX} + BCD_FIX)) // RULE11
    else $error("adjust dropped carry");
  chk_read_phase: assert property (rd_q |-> (state_q == S_EXEC) && (phase_q == 2'h1) ##1 !rd_q) // RULE12
    else $error("operand read outside second phase");

endmodule : csda_exec_unit
`default_nettype wire

/* File: verification/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// Self-checking bench: drivers queue expectations, one monitor compares them.
module testbench
  import csda_pkg::*;
;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, fetch_valid;
  logic        awready, wready, bvalid, arready, rvalid, fetch_ready, dmem_rd, no_operation;
  logic [7:0]  awaddr, araddr, dmem_rdata, w_out;
  logic [31:0] wdata, rdata;
  logic [15:0] fetch_insn, fetch_next;
  logic [1:0]  bresp, rresp, phase;
  logic [11:0] dmem_addr;
  int          n_mismatch = 0, total_checks = 0, cyc = 0;
  logic [33:0] q_rsp[$];   // Expected response code and read data.
  logic [11:0] q_addr[$];  // Expected operand address.
  logic [3:0]  q_nop[$];   // Expected count of discarded cycles.
  logic [7:0]  q_w[$];     // Expected working register after a run.
  logic        busy = 1'h0;     // An instruction is in flight.
  logic [3:0]  nop_cnt = 4'h0;  // Discarded cycles seen so far.

  csda_exec_unit u_csda_exec_unit (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .fetch_insn(fetch_insn), .fetch_next(fetch_next), .fetch_valid(fetch_valid),
    .fetch_ready(fetch_ready), .dmem_addr(dmem_addr), .dmem_rd(dmem_rd),
    .dmem_rdata(dmem_rdata), .working_register_alias(w_out), .phase(phase),
    .no_operation(no_operation));

  ////////////////////////////////////////////////////////////////////////////////
  // Free running 100 MHz clock.
  initial begin
    aclk = 1'h0;
    forever #5 aclk = ~aclk;
  end

  // Prints the counts and the verdict, then stops the run.
  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : end_sim

  // Counts one comparison and reports a difference at once.
  task automatic chk(input string what, input logic [33:0] e, input logic [33:0] s);
    total_checks++;
    if (e !== s) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", what, e, s);
    end
  endtask : chk

  ////////////////////////////////////////////////////////////////////////////////
  // Monitor: takes the oldest note whenever a result shows, and a hang guard.
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc > 20000) begin
      n_mismatch++;
      end_sim();
    end
    if (aresetn === 1'h1) begin
      if (bvalid === 1'h1 && bready && q_rsp.size() > 0) chk("bresp", q_rsp.pop_front(), {bresp, 32'h0});
      if (rvalid === 1'h1 && rready && q_rsp.size() > 0) chk("rdata", q_rsp.pop_front(), {rresp, rdata});
      if (dmem_rd === 1'h1) begin
        chk("phase", 34'h1, {32'h0, phase});
        if (q_addr.size() > 0) chk("dmem_addr", {22'h0, q_addr.pop_front()}, {22'h0, dmem_addr});
      end
      // Discarded cycles are counted from the take until fetch returns ready.
      if (fetch_valid && fetch_ready === 1'h1) begin
        busy    <= 1'h1;
        nop_cnt <= 4'h0;
      end else if (busy && fetch_ready === 1'h1) begin
        busy <= 1'h0;
        if (q_nop.size() > 0) chk("nop_cycles", {30'h0, q_nop.pop_front()}, {30'h0, nop_cnt});
        if (q_w.size() > 0) chk("w_out", {26'h0, q_w.pop_front()}, {26'h0, w_out});
      end else if (busy && no_operation === 1'h1) begin
        nop_cnt <= nop_cnt + 4'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Register write; address and data are released each on its own ready.
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ad, wd;
    q_rsp.push_back({er, 32'h0});
    awaddr <= a; awvalid <= 1'h1; wdata <= d; wvalid <= 1'h1; bready <= 1'h1;
    ad = 1'h0; wd = 1'h0;
    while (!(ad && wd)) begin
      @(posedge aclk);
      if (awready === 1'h1 && !ad) begin ad = 1'h1; awvalid <= 1'h0; end
      if (wready === 1'h1 && !wd) begin wd = 1'h1; wvalid <= 1'h0; end
    end
    do @(posedge aclk); while (bvalid !== 1'h1);
    bready <= 1'h0;
    @(posedge aclk);
  endtask : axi_wr

  // Register read; the expected response and data go to the queue.
  task automatic axi_rd(input logic [7:0] a, input logic [33:0] e);
    q_rsp.push_back(e);
    araddr <= a; arvalid <= 1'h1; rready <= 1'h1;
    do @(posedge aclk); while (arready !== 1'h1);
    arvalid <= 1'h0;
    do @(posedge aclk); while (rvalid !== 1'h1);
    rready <= 1'h0;
    @(posedge aclk);
  endtask : axi_rd

  // Offers one instruction with its follower; memory holds the byte meanwhile.
  task automatic run(input logic [15:0] op, input logic [15:0] nx, input logic [7:0] b);
    fetch_insn <= op; fetch_next <= nx; fetch_valid <= 1'h1; dmem_rdata <= b;
    do @(posedge aclk); while (fetch_ready !== 1'h1);
    fetch_valid <= 1'h0;
    do @(posedge aclk); while (fetch_ready !== 1'h1);
    dmem_rdata <= ~b;
    @(posedge aclk);
  endtask : run

  // Reference decimal adjust: returns carry and adjusted value.
  function automatic logic [8:0] daw_ref(input logic [7:0] w, input logic c, input logic dc);
    logic [8:0] s;
    s = {1'h0, w};
    if (w[3:0] > BCD_MAX || dc) s = s + 9'h006;
    if (s[8:4] > 5'h09 || c) return {1'h1, s[7:0] + 8'h60};
    return {c, s[7:0]};
  endfunction : daw_ref

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence.
  initial begin
    logic [7:0] w, b, f, da, db;
    logic [3:0] bank;
    logic [11:0] idx, ea;
    logic [8:0] sum, r;
    logic [1:0] fl;
    logic gt, a, ext, two, skip;
    int dec;
    aresetn = 1'h0; awvalid = 1'h0; wvalid = 1'h0; bready = 1'h0; arvalid = 1'h0;
    rready = 1'h0; fetch_valid = 1'h0; awaddr = 8'h00; araddr = 8'h00; wdata = 32'h0;
    fetch_insn = 16'h0; fetch_next = 16'h0; dmem_rdata = 8'h00;
    void'($urandom(32'hdcd3c096));
    repeat (16) @(posedge aclk);
    aresetn <= 1'h1;
    repeat (2) @(posedge aclk);
    // Reset values, then unmapped and read-only places.
    axi_rd(ADDR_WORKING_REGISTER_ALIAS, {26'h0, WORKING_REGISTER_ALIAS_RST});
    axi_rd(ADDR_FLAGS, 34'h0);
    axi_rd(ADDR_BANK, {30'h0, BANK_RST});
    axi_rd(ADDR_IDX, {22'h0, IDX_RST});
    axi_rd(ADDR_CTRL, 34'h0);
    axi_rd(8'h18, {2'h3, 32'h0});
    axi_wr(ADDR_STAT, 32'h0, 2'h3);
    // Compares: equal and off-by-one bytes, random banks, both follower sizes.
    for (int i = 0; i < 60; i++) begin
      gt = 1'($urandom_range(1)); a = 1'($urandom_range(1)); ext = 1'($urandom_range(1));
      two = 1'($urandom_range(1)); f = 8'($urandom); w = 8'($urandom);
      bank = 4'($urandom); idx = 12'($urandom); fl = 2'($urandom);
      b = (i % 4 == 0) ? w : (i % 4 == 1) ? w + 8'h01 : (i % 4 == 2) ? w - 8'h01 : 8'($urandom);
      if (a) ea = {bank, f};
      else if (gt && ext && f <= ILO_MAX) ea = idx + {4'h0, f};
      else ea = (f < ACC_SPLIT) ? {4'h0, f} : {ACC_HIGH, f};
      skip = gt ? (b > w) : (b < w);
      axi_wr(ADDR_WORKING_REGISTER_ALIAS, {24'h0, w}, 2'h0);
      axi_wr(ADDR_FLAGS, {30'h0, fl}, 2'h0);
      axi_wr(ADDR_BANK, {28'h0, bank}, 2'h0);
      axi_wr(ADDR_IDX, {20'h0, idx}, 2'h0);
      axi_wr(ADDR_CTRL, {31'h0, ext}, 2'h0);
      q_addr.push_back(ea);
      q_nop.push_back(skip ? (two ? 4'h8 : 4'h4) : 4'h0);
      q_w.push_back(w);
      run({gt ? OP_GT_TOP : OP_LT_TOP, a, f},
          two ? ((i % 2 == 1) ? {OP_2W_FF, 12'($urandom)} : {OP_2W_JMP, 10'($urandom)})
              : {4'h0, 12'($urandom)}, b);
      axi_rd(ADDR_WORKING_REGISTER_ALIAS, {26'h0, w});
      axi_rd(ADDR_FLAGS, {32'h0, fl});
    end
    // Decimal adjust: two fixed cases, then sums of random packed BCD pairs.
    for (int i = 0; i < 32; i++) begin
      da = {4'($urandom_range(9)), 4'($urandom_range(9))};
      db = {4'($urandom_range(9)), 4'($urandom_range(9))};
      sum = {1'h0, da} + {1'h0, db};
      fl = {(5'(da[3:0]) + 5'(db[3:0])) > 5'h0f, sum[8]};
      if (i < 2) begin
        sum = (i == 0) ? 9'h0a5 : 9'h0ce;
        fl = 2'h0;
      end
      r = daw_ref(sum[7:0], fl[0], fl[1]);
      dec = 10 * (da[7:4] + db[7:4]) + da[3:0] + db[3:0];
      if (i >= 2) chk("daw_ref", {25'h0, dec > 99, 4'(dec % 100 / 10), 4'(dec % 10)}, {25'h0, r});
      axi_wr(ADDR_WORKING_REGISTER_ALIAS, {23'h0, sum}, 2'h0);
      axi_wr(ADDR_FLAGS, {30'h0, fl}, 2'h0);
      q_nop.push_back(4'h0);
      q_w.push_back(r[7:0]);
      run(OP_DAW, 16'($urandom), 8'($urandom));
      axi_rd(ADDR_WORKING_REGISTER_ALIAS, {26'h0, r[7:0]});
      axi_rd(ADDR_FLAGS, {32'h0, fl[1], r[8]});
    end
    repeat (4) @(posedge aclk);
    end_sim();
  end
endmodule : testbench
`default_nettype wire
